// File: core/tcc_pkg.sv
// constants, register map and carrier types of the timer capture/compare unit
// assumes an apb master on the same clock; byte address is four times the register index
package tcc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CH_N   = 4;

  // register indices; byte address = index * 4
  localparam logic [7:0] IDX_CH01_MODE  = 8'h00_C1;
  localparam logic [7:0] IDX_CH1_LOW    = 8'h00_C2;
  localparam logic [7:0] IDX_CH1_HIGH   = 8'h00_C3;
  localparam logic [7:0] IDX_CH2_LOW    = 8'h00_C4;
  localparam logic [7:0] IDX_CH2_HIGH   = 8'h00_C5;
  localparam logic [7:0] IDX_CH3_LOW    = 8'h00_C6;
  localparam logic [7:0] IDX_CH3_HIGH   = 8'h00_C7;
  localparam logic [7:0] IDX_TIMER_CTRL = 8'h00_C8;
  localparam logic [7:0] IDX_IRQ_CTRL   = 8'h00_C9;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h00_CA;
  localparam logic [7:0] IDX_RELOAD_HI  = 8'h00_CB;
  localparam logic [7:0] IDX_COUNT_LOW  = 8'h00_CC;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h00_CD;
  localparam logic [7:0] IDX_CH23_MODE  = 8'h00_D1;
  localparam logic [7:0] IDX_SHADOW     = 8'h00_D2;

  localparam logic [7:0]  REG_RESET = 8'h00_00;
  localparam logic [15:0] CNT_MAX   = 16'hFF_FF;

  // timer control fields
  localparam int unsigned PS_LSB = 5;
  localparam int unsigned RL_LSB = 3;
  localparam int unsigned IN_LSB = 0;

  localparam logic [1:0] IN_STOP  = 2'h0;
  localparam logic [1:0] IN_TICK  = 2'h1;
  localparam logic [1:0] IN_EVENT = 2'h2;
  localparam logic [1:0] IN_GATED = 2'h3;
  localparam logic [1:0] RL_AUTO  = 2'h2;
  localparam logic [1:0] RL_PIN   = 2'h3;

  // channel modes
  localparam logic [2:0] MD_OFF     = 3'h0;
  localparam logic [2:0] MD_CMP_SIL = 3'h1;
  localparam logic [2:0] MD_CMP0    = 3'h2;
  localparam logic [2:0] MD_CMP1    = 3'h3;
  localparam logic [2:0] MD_CAP_R   = 3'h4;
  localparam logic [2:0] MD_CAP_F   = 3'h5;
  localparam logic [2:0] MD_CAP_B   = 3'h6;
  localparam logic [2:0] MD_CAP_SW  = 3'h7;

  // prescale divisors for codes 000..111; zero means no tick
  localparam logic [4:0] PS_DIV [8] = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h18, 5'h00};

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [CH_N-1:0] out;
    logic [CH_N-1:0] oe;
  } chan_drive_t;

endpackage

// File: core/timer_capture_compare_unit.sv
// 16-bit timer with four compare/capture channels behind an apb slave
// assumes apb on clock_i; pins are asynchronous and synchronised here
`timescale 1ns/1ns

module timer_capture_compare_unit (
  input  wire logic                    clock_i,
  input  wire logic                    nrst_i,
  input  wire tcc_pkg::apb_req_t       apb_i,
  output tcc_pkg::apb_rsp_t            apb_o,
  input  wire logic                    external_count_pin_i,
  input  wire logic                    reload_trigger_pin_i,
  input  wire logic [tcc_pkg::CH_N-1:0] chan_pin_i,
  output tcc_pkg::chan_drive_t         chan_pin_o,
  output logic                         irq_o
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic       rst_s1_q;
  logic       rst_n;
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_prev_q;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q   <= 6'h00;
      pin_s2_q   <= 6'h00;
      pin_prev_q <= 6'h00;
    end else begin
      pin_s1_q   <= {reload_trigger_pin_i, external_count_pin_i, chan_pin_i};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  wire [CH_N-1:0] chan_rise = pin_s2_q[3:0] & ~pin_prev_q[3:0];
  wire [CH_N-1:0] chan_fall = ~pin_s2_q[3:0] & pin_prev_q[3:0];
  wire            ext_level = pin_s2_q[4];
  wire            ext_fall  = ~pin_s2_q[4] & pin_prev_q[4];
  wire            trig_fall = ~pin_s2_q[5] & pin_prev_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [7:0]  timer_ctrl_q;
  logic [7:0]  irq_ctrl_q;
  logic [7:0]  ch01_mode_q;
  logic [7:0]  ch23_mode_q;
  logic [3:0]  shadow_q;
  logic [15:0] count_q;
  logic [15:0] chan_val_q [CH_N];
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  wire [7:0] idx     = apb_i.paddr[9:2];
  wire       aligned = (apb_i.paddr[1:0] == 2'h0) && (apb_i.paddr[ADDR_W-1:10] == '0);
  wire       access  = apb_i.psel & apb_i.penable;
  wire       done    = access & pready_q;
  wire       wr      = done & apb_i.pwrite;
  wire [7:0] wbyte   = apb_i.pwdata[7:0];

  wire hit_ch01   = aligned && idx == IDX_CH01_MODE;
  wire hit_ch23   = aligned && idx == IDX_CH23_MODE;
  wire hit_tctrl  = aligned && idx == IDX_TIMER_CTRL;
  wire hit_ictrl  = aligned && idx == IDX_IRQ_CTRL;
  wire hit_shadow = aligned && idx == IDX_SHADOW;
  wire hit_cnt_l  = aligned && idx == IDX_COUNT_LOW;
  wire hit_cnt_h  = aligned && idx == IDX_COUNT_HIGH;

  logic [CH_N-1:0] hit_val_l;
  logic [CH_N-1:0] hit_val_h;
  assign hit_val_l[0] = aligned && idx == IDX_RELOAD_LOW;
  assign hit_val_h[0] = aligned && idx == IDX_RELOAD_HI;
  assign hit_val_l[1] = aligned && idx == IDX_CH1_LOW;
  assign hit_val_h[1] = aligned && idx == IDX_CH1_HIGH;
  assign hit_val_l[2] = aligned && idx == IDX_CH2_LOW;
  assign hit_val_h[2] = aligned && idx == IDX_CH2_HIGH;
  assign hit_val_l[3] = aligned && idx == IDX_CH3_LOW;
  assign hit_val_h[3] = aligned && idx == IDX_CH3_HIGH;

  wire hit_any = hit_ch01 | hit_ch23 | hit_tctrl | hit_ictrl | hit_shadow
               | hit_cnt_l | hit_cnt_h | (|hit_val_l) | (|hit_val_h);

  logic [7:0] rd_val;
  always_comb begin
    rd_val = REG_RESET;
    if (hit_ch01)   rd_val = ch01_mode_q & 8'h77;
    if (hit_ch23)   rd_val = ch23_mode_q & 8'h77;
    if (hit_tctrl)  rd_val = timer_ctrl_q & 8'hFB;
    if (hit_ictrl)  rd_val = irq_ctrl_q;
    if (hit_shadow) rd_val = {4'h0, shadow_q};
    if (hit_cnt_l)  rd_val = count_q[7:0];
    if (hit_cnt_h)  rd_val = count_q[15:8];
    for (int k = 0; k < CH_N; k++) begin
      if (hit_val_l[k]) rd_val = chan_val_q[k][7:0];
      if (hit_val_h[k]) rd_val = chan_val_q[k][15:8];
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~hit_any;
      prdata_q  <= (access & ~pready_q & ~apb_i.pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_ctrl_q <= REG_RESET;
      ch01_mode_q  <= REG_RESET;
      ch23_mode_q  <= REG_RESET;
      shadow_q     <= 4'h0;
    end else begin
      if (wr && hit_tctrl)  timer_ctrl_q <= wbyte & 8'hFB;
      if (wr && hit_ch01)   ch01_mode_q  <= wbyte & 8'h77;
      if (wr && hit_ch23)   ch23_mode_q  <= wbyte & 8'h77;
      if (wr && hit_shadow) shadow_q     <= wbyte[3:0];
    end
  end

  wire [2:0] ps_sel = timer_ctrl_q[PS_LSB +: 3];
  wire [1:0] rl_sel = timer_ctrl_q[RL_LSB +: 2];
  wire [1:0] in_sel = timer_ctrl_q[IN_LSB +: 2];

  logic [2:0] mode [CH_N];
  assign mode[0] = ch01_mode_q[2:0];
  assign mode[1] = ch01_mode_q[6:4];
  assign mode[2] = ch23_mode_q[2:0];
  assign mode[3] = ch23_mode_q[6:4];

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and count enable

  logic [4:0] ps_cnt_q;
  logic       ext_evt_q;

  wire [4:0] ps_div  = PS_DIV[ps_sel];
  wire       ps_wrap = (ps_div != 5'h00) && (ps_cnt_q >= ps_div - 5'h01);
  wire       tick    = ps_wrap;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ps_cnt_q  <= 5'h00;
      ext_evt_q <= 1'b0;
    end else begin
      ps_cnt_q  <= ps_wrap ? 5'h00 : ps_cnt_q + 5'h01;
      ext_evt_q <= ext_fall;
    end
  end

  logic inc;
  always_comb begin
    case (in_sel)
      IN_STOP:  inc = 1'b0;
      IN_TICK:  inc = tick;
      IN_EVENT: inc = ext_evt_q;
      IN_GATED: inc = tick & ext_level;
      default:  inc = 1'b0;
    endcase
  end

  wire overflow = inc && count_q == CNT_MAX;
  wire reload   = (rl_sel == RL_AUTO && overflow) || (rl_sel == RL_PIN && trig_fall);

  ////////////////////////////////////////////////////////////////////////////
  // timer count

  logic upd_q;
  logic ovf_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
      upd_q   <= 1'b0;
      ovf_q   <= 1'b0;
    end else begin
      upd_q <= inc | reload;
      ovf_q <= overflow;
      if (wr && hit_cnt_l) begin
        count_q[7:0] <= wbyte;
      end else if (wr && hit_cnt_h) begin
        count_q[15:8] <= wbyte;
      end else if (reload) begin
        count_q <= chan_val_q[0];
      end else if (inc) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels

  logic [CH_N-1:0] evt;
  logic [CH_N-1:0] pin_out_q;
  logic [CH_N-1:0] pin_oe_q;

  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    wire is_cmp  = mode[c] == MD_CMP_SIL || mode[c] == MD_CMP0 || mode[c] == MD_CMP1;
    wire match   = is_cmp && upd_q && count_q == chan_val_q[c];
    wire hw_cap  = (mode[c] == MD_CAP_R && chan_rise[c])
                || (mode[c] == MD_CAP_F && chan_fall[c])
                || (mode[c] == MD_CAP_B && (chan_rise[c] | chan_fall[c]));
    wire sw_cap  = mode[c] == MD_CAP_SW && wr && hit_val_l[c];
    assign evt[c] = match | hw_cap | sw_cap;

    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        chan_val_q[c] <= 16'h0000;
      end else if (hw_cap || sw_cap) begin
        chan_val_q[c] <= count_q;
      end else if (wr && hit_val_l[c]) begin
        chan_val_q[c][7:0] <= wbyte;
      end else if (wr && hit_val_h[c]) begin
        chan_val_q[c][15:8] <= wbyte;
      end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        pin_out_q[c] <= 1'b0;
        pin_oe_q[c]  <= 1'b0;
      end else begin
        pin_oe_q[c] <= mode[c] == MD_CMP0 || mode[c] == MD_CMP1;
        if (mode[c] == MD_CMP0) begin
          if (match) pin_out_q[c] <= 1'b1;
          else if (ovf_q) pin_out_q[c] <= 1'b0;
        end else if (mode[c] == MD_CMP1) begin
          if (match) pin_out_q[c] <= shadow_q[c];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and interrupt

  // a hardware event in the clearing cycle keeps its flag
  wire [3:0] flag_d = ((wr && hit_ictrl) ? wbyte[3:0] : irq_ctrl_q[3:0]) | evt;
  wire [3:0] ena_d  = (wr && hit_ictrl) ? wbyte[7:4] : irq_ctrl_q[7:4];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_ctrl_q <= REG_RESET;
      irq_o      <= 1'b0;
    end else begin
      irq_ctrl_q <= {ena_d, flag_d};
      irq_o      <= |(ena_d & flag_d);
    end
  end

  assign apb_o.prdata    = prdata_q;
  assign apb_o.pready    = pready_q;
  assign apb_o.pslverr   = pslverr_q;
  assign chan_pin_o.out  = pin_out_q;
  assign chan_pin_o.oe   = pin_oe_q;

endmodule

// File: sim/tcc_assertions.sv
// port-level assertions for the timer capture/compare unit
// assumes the unit's apb port runs on clock_i
`timescale 1ns/1ns

module tcc_assertions (
  input wire logic                 clock_i,
  input wire logic                 nrst_i,
  input wire tcc_pkg::apb_req_t    apb_i,
  input wire tcc_pkg::apb_rsp_t    apb_o,
  input wire tcc_pkg::chan_drive_t chan_pin_o,
  input wire logic                 irq_o
);
  import tcc_pkg::*;
  wire logic [7:0] idx = apb_i.paddr[9:2];
  wire logic       hit = apb_i.paddr[1:0] == 2'h0 && apb_i.paddr[11:10] == 2'h0 &&
                   ((idx >= IDX_CH01_MODE && idx <= IDX_COUNT_HIGH) || idx == IDX_CH23_MODE || idx == IDX_SHADOW);
  wire logic       rd_ok = apb_o.pready && !apb_i.pwrite && hit;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence setup_s;
    apb_i.psel && !apb_i.penable;
  endsequence
  sequence answer_s;
    apb_i.penable && !apb_o.pready ##1 apb_o.pready;
  endsequence
  a_setup_answered: assert property (setup_s |=> answer_s) else $error("apb answer late");
  a_ready_qualified: assert property (apb_o.pready |-> apb_i.psel && apb_i.penable) else $error("stray pready");
  a_ready_single: assert property (apb_o.pready |=> !apb_o.pready) else $error("pready too long");
  a_error_unmapped: assert property (apb_o.pready |-> apb_o.pslverr == !hit) else $error("pslverr wrong");
  a_error_ready: assert property (apb_o.pslverr |-> apb_o.pready) else $error("pslverr alone");
  a_data_idle: assert property (!apb_o.pready || apb_i.pwrite |-> apb_o.prdata == 32'h0000_0000) else $error("prdata");
  a_irq_merge: assert property (rd_ok && idx == IDX_IRQ_CTRL |->
    $past(irq_o) == |(apb_o.prdata[7:4] & apb_o.prdata[3:0])) else $error("irq merge");
  a_mode_unused: assert property (rd_ok && (idx == IDX_CH01_MODE || idx == IDX_CH23_MODE) |->
    !apb_o.prdata[7] && !apb_o.prdata[3]) else $error("mode bits 7 3");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |->
    !irq_o && chan_pin_o == '0 && !apb_o.pready) else $error("outputs in reset");
endmodule

bind timer_capture_compare_unit tcc_assertions chk (.clock_i(clock_i), .nrst_i(nrst_i), .apb_i(apb_i),
  .apb_o(apb_o), .chan_pin_o(chan_pin_o), .irq_o(irq_o));

// File: sim/tcc_pin_model.sv
// far side: drives count, reload trigger and channel pins
// assumes the caller's clock; all changes follow a rising edge
`timescale 1ns/1ns

module tcc_pin_model (
  input  wire logic                     clock_i,
  output logic                          count_o,
  output logic                          reload_o,
  output logic [tcc_pkg::CH_N-1:0]      chan_o
);
  initial begin
    count_o = 1'b1;
    reload_o = 1'b1;
    chan_o = '0;
  end
  // each level held 4 cycles so the sampler sees it
  task automatic count_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock_i);
      count_o <= 1'b0;
      repeat (4) @(posedge clock_i);
      count_o <= 1'b1;
    end
  endtask
  task automatic count_level(input logic v);
    @(posedge clock_i);
    count_o <= v;
  endtask
  task automatic reload_fall();
    @(posedge clock_i);
    reload_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    reload_o <= 1'b1;
  endtask
  task automatic set_chan(input int c, input logic v);
    @(posedge clock_i);
    chan_o[c] <= v;
  endtask
endmodule

// File: sim/tb.sv
// self-checking bench for the timer capture/compare unit
// assumes tcc_pkg, the unit, its checker and the pin model
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end

module tb;
  import tcc_pkg::*;
  logic        clock_i;
  logic        nrst_i;
  apb_req_t    apb_i;
  apb_rsp_t    apb_o;
  chan_drive_t chan_pin_o;
  logic        irq_o;
  logic        cnt_pin;
  logic        rl_pin;
  logic [3:0]  chan_pin;
  logic [7:0]  rdata;
  logic        err;
  logic [15:0] v;
  int          fails;
  int          tests_run;
  int          n;
  int          div [8] = '{1, 2, 4, 6, 8, 12, 24, 1};
  logic [7:0]  rw_idx [6] = '{IDX_CH01_MODE, IDX_CH1_LOW, IDX_CH3_HIGH, IDX_TIMER_CTRL, IDX_IRQ_CTRL, IDX_CH23_MODE};
  logic [7:0]  rw_msk [6] = '{8'h77, 8'hFF, 8'hFF, 8'hFB, 8'hFF, 8'h77};

  timer_capture_compare_unit dut (.clock_i(clock_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
    .external_count_pin_i(cnt_pin), .reload_trigger_pin_i(rl_pin), .chan_pin_i(chan_pin),
    .chan_pin_o(chan_pin_o), .irq_o(irq_o));
  tcc_pin_model pins (.clock_i(clock_i), .count_o(cnt_pin), .reload_o(rl_pin), .chan_o(chan_pin));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    apb_i <= '{paddr: {2'b00, idx, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
    @(posedge clock_i);
    apb_i.penable <= 1'b1;
    do @(posedge clock_i); while (apb_o.pready !== 1'b1);
    rdata = apb_o.prdata[7:0];
    err = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK($sformatf("reg %h", idx), e, rdata)
  endtask
  task automatic set_count(input logic [15:0] c);
    wr(IDX_COUNT_LOW, c[7:0]);
    wr(IDX_COUNT_HIGH, c[15:8]);
  endtask
  // ticks seen over a span of cycles for a prescale code; code 111 never ticks
  function automatic logic [7:0] ticks(input int code, input int cycles);
    return (code == 7) ? 8'h00 : 8'(cycles / div[code]);
  endfunction
  task automatic wait_pin(input logic e);
    for (int i = 0; i < 100 && chan_pin_o.out[3] !== e; i++) @(posedge clock_i);
    `CHK("pin3", e, chan_pin_o.out[3])
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #400_000;
    fails++;
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8c34dd6a));
    nrst_i = 1'b0;
    apb_i = '0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int i = 8'hC0; i <= 8'hD2; i++) begin
      xfer(1'b0, i[7:0], 8'h00);
      `CHK("zero", 8'h00, rdata)
      `CHK("err", !((i >= 8'hC1 && i <= 8'hCD) || i >= 8'hD1), err)
    end
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wr(rw_idx[i], v[7:0]);
      rd_chk(rw_idx[i], v[7:0] & rw_msk[i]);
      wr(rw_idx[i], 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      wr(IDX_IRQ_CTRL, (8'h10 << c) | (8'h01 << c));
      @(posedge clock_i);
      `CHK("irq", 1'b1, irq_o)
      rd_chk(IDX_IRQ_CTRL, (8'h10 << c) | (8'h01 << c));
      wr(IDX_IRQ_CTRL, (8'h10 << ((c + 1) % 4)) | (8'h01 << c));
      @(posedge clock_i);
      `CHK("irq", 1'b0, irq_o)
    end
    wr(IDX_IRQ_CTRL, 8'h00);
    for (int p = 0; p < 8; p++) begin
      set_count(16'h0000);
      wr(IDX_TIMER_CTRL, {p[2:0], 5'h01});
      repeat (div[p] * 5 - 4) @(posedge clock_i);
      wr(IDX_TIMER_CTRL, {p[2:0], 5'h00});
      rd_chk(IDX_COUNT_LOW, ticks(p, div[p] * 5));
    end
    set_count(16'h0000);
    wr(IDX_TIMER_CTRL, 8'h02);
    n = $urandom_range(1, 9);
    pins.count_pulses(n);
    repeat (8) @(posedge clock_i);
    wr(IDX_TIMER_CTRL, 8'h00);
    rd_chk(IDX_COUNT_LOW, n[7:0]);
    pins.count_level(1'b0);
    set_count(16'h0000);
    wr(IDX_TIMER_CTRL, 8'h03);
    n = $urandom_range(5, 40);
    pins.count_level(1'b1);
    repeat (n - 1) @(posedge clock_i);
    pins.count_level(1'b0);
    repeat (6) @(posedge clock_i);
    wr(IDX_TIMER_CTRL, 8'h00);
    rd_chk(IDX_COUNT_LOW, n[7:0]);
    pins.count_level(1'b1);
    wr(IDX_RELOAD_LOW, 8'h34);
    wr(IDX_RELOAD_HI, 8'h12);
    for (int r = 0; r < 4; r++) begin
      set_count(16'h0000);
      wr(IDX_TIMER_CTRL, {3'h0, r[1:0], 3'h0});
      pins.reload_fall();
      repeat (6) @(posedge clock_i);
      rd_chk(IDX_COUNT_LOW, r == 3 ? 8'h34 : 8'h00);
      rd_chk(IDX_COUNT_HIGH, r == 3 ? 8'h12 : 8'h00);
    end
    set_count(16'hFFFE);
    wr(IDX_TIMER_CTRL, 8'h11);
    wr(IDX_TIMER_CTRL, 8'h00);
    rd_chk(IDX_COUNT_HIGH, 8'h12);
    set_count(16'h00FE);
    wr(IDX_TIMER_CTRL, 8'h01);
    wr(IDX_TIMER_CTRL, 8'h00);
    rd_chk(IDX_COUNT_HIGH, 8'h01);
    v = $urandom;
    set_count(v);
    wr(IDX_CH01_MODE, 8'h70);
    wr(IDX_CH1_LOW, ~v[7:0]);
    rd_chk(IDX_CH1_LOW, v[7:0]);
    rd_chk(IDX_CH1_HIGH, v[15:8]);
    rd_chk(IDX_IRQ_CTRL, 8'h02);
    wr(IDX_CH01_MODE, 8'h00);
    for (int m = 4; m < 7; m++) begin
      wr(IDX_CH23_MODE, 8'h00);
      wr(IDX_CH2_LOW, 8'h00);
      set_count(16'h00A0 + m);
      wr(IDX_CH23_MODE, m[7:0]);
      pins.set_chan(2, 1'b1);
      repeat (6) @(posedge clock_i);
      rd_chk(IDX_CH2_LOW, m == 5 ? 8'h00 : 8'hA0 + m);
      set_count(16'h00B0 + m);
      pins.set_chan(2, 1'b0);
      repeat (6) @(posedge clock_i);
      rd_chk(IDX_CH2_LOW, m == 4 ? 8'hA0 + m : 8'hB0 + m);
    end
    wr(IDX_IRQ_CTRL, 8'h00);
    wr(IDX_CH3_LOW, 8'h10);
    wr(IDX_CH2_LOW, 8'h08);
    set_count(16'h0000);
    wr(IDX_CH23_MODE, 8'h21);
    wr(IDX_TIMER_CTRL, 8'h01);
    wait_pin(1'b1);
    `CHK("oe3", 1'b1, chan_pin_o.oe[3])
    `CHK("oe2", 1'b0, chan_pin_o.oe[2])
    wr(IDX_TIMER_CTRL, 8'h00);
    set_count(16'hFFFC);
    wr(IDX_TIMER_CTRL, 8'h01);
    wait_pin(1'b0);
    wr(IDX_TIMER_CTRL, 8'h00);
    wr(IDX_SHADOW, 8'h08);
    wr(IDX_CH23_MODE, 8'h30);
    set_count(16'h0000);
    wr(IDX_TIMER_CTRL, 8'h01);
    wait_pin(1'b1);
    wr(IDX_TIMER_CTRL, 8'h00);
    wr(IDX_SHADOW, 8'h00);
    set_count(16'hFFFC);
    wr(IDX_TIMER_CTRL, 8'h01);
    repeat (10) @(posedge clock_i);
    `CHK("pin3", 1'b1, chan_pin_o.out[3])
    wait_pin(1'b0);
    wr(IDX_TIMER_CTRL, 8'h00);
    rd_chk(IDX_IRQ_CTRL, 8'h0C);
    stop_test();
  end
endmodule
